// *** hw/host_port_ctrl.sv ***
/*
 * Host-side controller of the multiplexed 16-bit host_port. Software
 * orders one halfword cycle at a time over APB; the controller runs the
 * select, strobe, control and data pins and waits on port_wait_n.
 * Assumes the port pins are asynchronous to clk and that the bench
 * resolves the host_data_bus wire from the output enables.
 * Assumes software configures the port and loads its address registers
 * through ordinary halfword cycles before moving data; the controller
 * never pairs halfwords itself.
 */
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "host_port_params.svh"

module host_port_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output host_port_pkg::port_pins_t port_pins,
  input wire logic port_wait_n,
  input wire logic [15:0] host_data_bus_in,
  output logic [15:0] host_data_bus_out,
  output logic host_data_bus_oe
);
  import host_port_pkg::*;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic wait_meta_q;
  logic wait_sync_q;
  logic [15:0] data_meta_q;
  logic [15:0] data_sync_q;

  // the data bus is synchronised bit by bit; that is safe only because
  // it is read after ready has been seen and the bus has stood still
  // the first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_meta_q <= 1'b0;
      wait_sync_q <= 1'b0;
      data_meta_q <= 16'h0000;
      data_sync_q <= 16'h0000;
    end else begin
      wait_meta_q <= port_wait_n;
      wait_sync_q <= wait_meta_q;
      data_meta_q <= host_data_bus_in;
      data_sync_q <= data_meta_q;
    end
  end

  // ************************************************************
  // apb slave and own registers
  // ************************************************************
  logic [2:0] config_q, config_d;
  port_cmd_t cmd_q, cmd_d;
  logic [15:0] wdata_q, wdata_d;
  logic [15:0] rdata_q, rdata_d;
  logic done_q, done_d;
  logic [31:0] prdata_q, prdata_d;
  logic err_q, err_d;
  logic launch;
  logic finish;
  logic capture;
  logic busy;
  logic bus_setup;
  logic bus_write;
  logic mapped;
  seq_state_t state_q, state_d;

  assign busy = (state_q != ST_IDLE);
  assign bus_setup = psel & ~penable;
  assign bus_write = psel & penable & pwrite & ~err_q;
  assign launch = bus_write & (paddr == `REG_COMMAND);
  // every access answers in its first access cycle
  assign pready = psel & penable;
  assign pslverr = psel & penable & err_q;
  assign prdata = prdata_q;

  always_comb begin
    mapped = (paddr == `REG_CONFIG) || (paddr == `REG_COMMAND) ||
             (paddr == `REG_WDATA) || (paddr == `REG_RDATA) ||
             (paddr == `REG_STATUS);
    prdata_d = prdata_q;
    err_d = err_q;
    config_d = config_q;
    cmd_d = cmd_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    done_d = done_q;
    // decode in the setup cycle so data and error come from flops
    if (bus_setup) begin
      // a new order while a cycle runs would tear the pins, refuse it;
      // status stays writable so a finished cycle can always be cleared,
      // and reads of mapped registers are never refused, so software may poll while busy
      err_d = ~mapped | (pwrite & busy & (paddr != `REG_STATUS)) |
              (pwrite & (paddr == `REG_RDATA));
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        `REG_CONFIG: prdata_d = {29'h0, config_q};
        `REG_COMMAND: prdata_d = {28'h0, cmd_q.halfword_second,
                                  cmd_q.read_not_write,
                                  cmd_q.access_type_sel};
        `REG_WDATA: prdata_d = {16'h0, wdata_q};
        `REG_RDATA: prdata_d = {16'h0, rdata_q};
        `REG_STATUS: prdata_d = {29'h0, ~wait_sync_q, done_q, busy};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    if (bus_write && paddr == `REG_CONFIG) begin
      config_d = pwdata[2:0];
    end
    if (bus_write && paddr == `REG_WDATA) begin
      wdata_d = pwdata[15:0];
    end
    // the order is latched whole so pins stay steady for the cycle
    if (launch) begin
      cmd_d.access_type_sel = pwdata[`CMD_TYPE_HI:`CMD_TYPE_LO];
      cmd_d.read_not_write = pwdata[`CMD_READ];
      cmd_d.halfword_second = pwdata[`CMD_HALFWORD];
      cmd_d.wdata = wdata_q;
      done_d = 1'b0;
    end
    if (bus_write && paddr == `REG_STATUS && pwdata[`STAT_DONE]) begin
      done_d = 1'b0;
    end
    if (capture) begin
      rdata_d = data_sync_q;
    end
    // completion wins over a clear in the same cycle
    if (finish) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
      config_q <= `CONFIG_RESET;
      cmd_q <= '0;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      err_q <= err_d;
      config_q <= config_d;
      cmd_q <= cmd_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
    end
  end

  // ************************************************************
  // halfword cycle sequencer
  // ************************************************************
  logic [7:0] cnt_q, cnt_d;
  port_pins_t pins_q, pins_d;
  logic [15:0] dout_q, dout_d;
  logic oe_q, oe_d;
  logic idle_level;
  logic use_b;
  logic on_wire;

  assign capture = (state_q == ST_CAPTURE) && (cnt_q == 8'h01) &&
                   cmd_q.read_not_write;
  assign finish = (state_q == ST_GAP) && (cnt_q == 8'h01);

  // one halfword cycle, in edges after the launching write E:
  //   E+1  select falls; controls and write data change on the same edge
  //   E+3  chosen strobe goes active, so the merged strobe falls
  //   E+4  settle ends; from here the synchronised ready is watched
  //   k    port_wait_n seen low at the pin
  //   k+3  capture state entered, data sync given two stages to drain
  //   k+5  read data taken into the read-back register
  //   k+6  strobe back at rest; the port latches write data here
  //   k+7  select rises after one hold cycle, bus released
  //   k+8  done set, busy clears
  // every pin follows the registered state, so select, strobes and
  // data move on the same edges and select always frames the strobe
  // limitation: a port that never lowers ready hangs the sequencer,
  // as no timeout is kept; software sees busy stay set and must reset
  always_comb begin
    // resting level of both strobes: one for active-low, zero else
    idle_level = ~config_q[`CFG_ACTIVE_HIGH];
    // split mode: reads strobe a, writes strobe b
    if (config_q[`CFG_SPLIT_STROBES]) begin
      use_b = ~cmd_q.read_not_write;
    end else begin
      use_b = config_q[`CFG_STROBE_ON_B];
    end
    // strobe asserted from settle to capture; both strobes differ only
    // then, so the merged strobe falls and rises inside select low
    on_wire = (state_q == ST_SETTLE) || (state_q == ST_WAIT) ||
              (state_q == ST_CAPTURE);
    state_d = state_q;
    cnt_d = cnt_q;
    if (cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01;
    end
    unique case (state_q)
      ST_IDLE: begin
        if (launch) begin
          state_d = ST_SETUP;
          cnt_d = `SETUP_CYC;
        end
      end
      // select low with controls steady before the strobe falls
      ST_SETUP: begin
        if (cnt_q == 8'h01) begin
          state_d = ST_SETTLE;
          cnt_d = `SETTLE_CYC;
        end
      end
      // ready is only meaningful once the port has seen the strobe
      ST_SETTLE: begin
        if (cnt_q == 8'h01) begin
          state_d = ST_WAIT;
        end
      end
      // no cycle count is assumed: low ready ends the wait
      ST_WAIT: begin
        if (!wait_sync_q) begin
          state_d = ST_CAPTURE;
          cnt_d = `CAPTURE_CYC;
        end
      end
      // data sync lags by the same two stages, let it settle
      ST_CAPTURE: begin
        if (cnt_q == 8'h01) begin
          state_d = ST_HOLD;
          cnt_d = `HOLD_CYC;
        end
      end
      ST_HOLD: begin
        if (cnt_q == 8'h01) begin
          state_d = ST_GAP;
          cnt_d = `GAP_CYC;
        end
      end
      ST_GAP: begin
        if (cnt_q == 8'h01) begin
          state_d = ST_IDLE;
        end
      end
      // an unused code falls back to rest rather than locking up
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // select stays low around the whole strobe, never strobes alone
    pins_d.port_select_n = (state_q == ST_IDLE) ||
                           (state_q == ST_GAP);
    pins_d.data_strobe_a = idle_level ^ (on_wire & ~use_b);
    pins_d.data_strobe_b = idle_level ^ (on_wire & use_b);
    pins_d.access_type_sel = cmd_q.access_type_sel;
    pins_d.read_not_write = cmd_q.read_not_write;
    pins_d.halfword_second = cmd_q.halfword_second;
    if (state_q == ST_IDLE) begin
      pins_d.data_strobe_a = idle_level;
      pins_d.data_strobe_b = idle_level;
    end
    // write data is held through the strobe rise and hold time
    oe_d = ~cmd_q.read_not_write && (state_q != ST_IDLE) &&
           (state_q != ST_GAP);
    dout_d = cmd_q.wdata;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      pins_q <= '{port_select_n: 1'b1, data_strobe_a: 1'b1,
                  data_strobe_b: 1'b1, access_type_sel: 2'h0,
                  read_not_write: 1'b1, halfword_second: 1'b0};
      dout_q <= 16'h0000;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pins_q <= pins_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
    end
  end

  // all pins register one cycle behind the state that they follow
  assign port_pins = pins_q;
  assign host_data_bus_out = dout_q;
  assign host_data_bus_oe = oe_q;

endmodule

// *** hw/host_port_params.svh ***
/*
 * Constants of the host-side controller for the multiplexed 16-bit
 * host_port: register offsets, field positions, reset values, access
 * codes and pin timing.
 * Assumes a 40 MHz system clock and an APB bus with 8 address bits.
 */
// Function
// - host configures port_control_reg before first transfer
// - host loads address registers before data accesses
// - host drives access_type_sel and read_not_write
// - host captures read data, then releases strobe
// - write: wait ready low, then raise strobe
// - select held low throughout any strobe activity
// - select may share one strobe signal
// - never use select alone as strobe
// - single active-low strobe, other held one
// - single active-high strobe, other held zero
// - separate read/write strobes, still drive direction
// - read_not_write high reads, low writes
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

// ************************************************************
// register map of the controller, one word each
// ************************************************************
`define REG_CONFIG 8'h00
`define REG_COMMAND 8'h04
`define REG_WDATA 8'h08
`define REG_RDATA 8'h0C
`define REG_STATUS 8'h10

// ************************************************************
// field positions
// ************************************************************
`define CFG_ACTIVE_HIGH 0
`define CFG_STROBE_ON_B 1
`define CFG_SPLIT_STROBES 2
`define CMD_TYPE_LO 0
`define CMD_TYPE_HI 1
`define CMD_READ 2
`define CMD_HALFWORD 3
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_WAIT 2
`define CONFIG_RESET 3'h0

// ************************************************************
// access_type_sel codes
// ************************************************************
`define ACC_CONTROL 2'h0
`define ACC_DATA_INC 2'h1
`define ACC_ADDRESS 2'h2
`define ACC_DATA 2'h3

// ************************************************************
// pin timing, in ns and in 25 ns clock cycles
// ************************************************************
`define CLK_MHZ 40
`define SETUP_NS 30
`define SETTLE_NS 50
`define HOLD_NS 20
`define GAP_NS 40
`define NS_TO_CYC(ns) (((ns) * `CLK_MHZ + 999) / 1000)
`define SETUP_CYC 8'(`NS_TO_CYC(`SETUP_NS))
`define SETTLE_CYC 8'(`NS_TO_CYC(`SETTLE_NS))
`define HOLD_CYC 8'(`NS_TO_CYC(`HOLD_NS))
`define GAP_CYC 8'(`NS_TO_CYC(`GAP_NS))
`define CAPTURE_CYC 8'h2

`endif

// *** hw/host_port_pkg.sv ***
/*
 * Types of the host-side controller: pin bundle towards the port,
 * latched command and sequencer states.
 * Assumes the constants header is included by the design file.
 */
package host_port_pkg;

  // control pins driven towards the port, all from flip-flops
  typedef struct packed {
    logic port_select_n;
    logic data_strobe_a;
    logic data_strobe_b;
    logic [1:0] access_type_sel;
    logic read_not_write;
    logic halfword_second;
  } port_pins_t;

  // one halfword cycle as software ordered it
  typedef struct packed {
    logic [1:0] access_type_sel;
    logic read_not_write;
    logic halfword_second;
    logic [15:0] wdata;
  } port_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_SETTLE,
    ST_WAIT,
    ST_CAPTURE,
    ST_HOLD,
    ST_GAP
  } seq_state_t;

endpackage

// *** tb/host_port_monitor.sv ***
/* pin checks on the host side of the host_port.
   assumes a bind onto host_port_ctrl and a single clock. */
`timescale 1ns/1ps
module host_port_check (
  input wire logic clk,
  input wire logic rst,
  input wire host_port_pkg::port_pins_t port_pins,
  input wire logic port_wait_n,
  input wire logic [15:0] host_data_bus_out,
  input wire logic host_data_bus_oe
);
  import host_port_pkg::*;
  // ********
  // helpers
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire sel = !port_pins.port_select_n;
  wire act = port_pins.data_strobe_a ^ port_pins.data_strobe_b;
  wire [3:0] ctl = {port_pins.access_type_sel, port_pins.read_not_write,
    port_pins.halfword_second};
  // ********
  // checks
  // ********
  property p_idle; !sel |-> !act; endproperty
  a_idle: assert property (p_idle)
    else $error("strobe active while deselected");
  property p_ctl; sel && $past(sel) |-> $stable(ctl); endproperty
  a_ctl: assert property (p_ctl)
    else $error("controls moved during a cycle");
  property p_setup; $rose(act) |-> $past(sel, 1) && $past(sel, 2); endproperty
  a_setup: assert property (p_setup)
    else $error("strobe without select setup");
  property p_rel; sel && $fell(act) |-> !$past(port_wait_n, 3); endproperty
  a_rel: assert property (p_rel)
    else $error("strobe released before ready");
  property p_oe_dir; host_data_bus_oe |-> !port_pins.read_not_write; endproperty
  a_oe_dir: assert property (p_oe_dir)
    else $error("bus driven on a read");
  property p_oe_sel; host_data_bus_oe |-> sel; endproperty
  a_oe_sel: assert property (p_oe_sel)
    else $error("bus driven while deselected");
  property p_wd; host_data_bus_oe && $past(host_data_bus_oe) |->
    $stable(host_data_bus_out); endproperty
  a_wd: assert property (p_wd)
    else $error("write data moved while driven");
  property p_nocs; $fell(port_pins.port_select_n) |-> !act ##1 !act;
  endproperty
  a_nocs: assert property (p_nocs)
    else $error("select used as strobe");
endmodule
bind host_port_ctrl host_port_check i_check (.clk(clk), .rst(rst),
  .port_pins(port_pins), .port_wait_n(port_wait_n),
  .host_data_bus_out(host_data_bus_out),
  .host_data_bus_oe(host_data_bus_oe));

// *** tb/port_device.sv ***
/* behavioural model of the documented port device.
   assumes pins from flip-flops and a resolved data bus. */
`timescale 1ns/1ps
`include "host_port_params.svh"
module port_device (
  input wire logic clk,
  input wire logic rst,
  input wire host_port_pkg::port_pins_t port_pins,
  input wire logic [15:0] host_data_bus,
  input wire logic [3:0] delay,
  output logic port_wait_n,
  output logic [15:0] dev_bus
);
  import host_port_pkg::*;
  localparam int SPLIT = 1; // split_addr_mode bit
  localparam int ASEL = 2; // addr_reg_select bit
  logic [15:0] mem [0:15];
  logic [15:0] ctl_q, ra_q, wa_q, out_q;
  logic [1:0] ty_q;
  logic rd_q, act_q, ok_q;
  logic [3:0] cnt_q;
  wire act = !port_pins.port_select_n &&
    (port_pins.data_strobe_a ^ port_pins.data_strobe_b);
  // wait until data valid, low when deselected
  assign port_wait_n = !port_pins.port_select_n && !ok_q;
  // released bus shows the inverse so a stale value never passes
  assign dev_bus = (rd_q && act && ok_q) ? out_q : ~out_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {ctl_q, ra_q, wa_q, out_q, ty_q, rd_q, act_q, ok_q, cnt_q} <= '0;
      for (int i = 0; i < 16; i++) mem[i] <= 16'h0;
    end else begin
      act_q <= act;
      if (port_pins.port_select_n) ok_q <= 1'b0;
      // latch controls at strobe fall
      if (act && !act_q) begin
        ty_q <= port_pins.access_type_sel;
        rd_q <= port_pins.read_not_write;
        cnt_q <= delay;
      end else if (act && !ok_q && cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
      else if (act && !ok_q) begin
        ok_q <= 1'b1;
        // own fetch path
        if (rd_q) case (ty_q)
          `ACC_CONTROL: out_q <= ctl_q;
          `ACC_ADDRESS: out_q <= (ctl_q[SPLIT] && !ctl_q[ASEL]) ? wa_q : ra_q;
          default: begin
            out_q <= mem[ra_q[3:0]];
            if (ty_q == `ACC_DATA_INC) ra_q <= ra_q + 16'h1;
          end
        endcase
      end
      // capture at strobe rise, then store
      if (!act && act_q && !rd_q) case (ty_q)
        `ACC_CONTROL: ctl_q <= host_data_bus;
        `ACC_ADDRESS: begin
          if (!ctl_q[SPLIT] || ctl_q[ASEL]) ra_q <= host_data_bus;
          if (!ctl_q[SPLIT] || !ctl_q[ASEL]) wa_q <= host_data_bus;
        end
        default: begin
          mem[wa_q[3:0]] <= host_data_bus;
          if (ty_q == `ACC_DATA_INC) wa_q <= wa_q + 16'h1;
        end
      endcase
    end
  end
endmodule

// *** tb/testbench.sv ***
/* self-checking bench of the host_port controller.
   assumes the device model and the bound pin checker. */
`timescale 1ns/1ps
`include "host_port_params.svh"
module testbench;
  import host_port_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, wait_n, oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  port_pins_t pins;
  logic [15:0] bus_out, dev_bus, bus;
  logic [3:0] delay;
  int n_mismatch, checks_done;
  assign bus = oe ? bus_out : dev_bus; // wire level from both drivers
  host_port_ctrl i_host_port_ctrl (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_pins(pins),
    .port_wait_n(wait_n), .host_data_bus_in(bus),
    .host_data_bus_out(bus_out), .host_data_bus_oe(oe));
  port_device i_port_device (.clk(clk), .rst(rst), .port_pins(pins),
    .host_data_bus(bus), .delay(delay), .port_wait_n(wait_n),
    .dev_bus(dev_bus));
  // ********
  // tasks
  // ********
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one transfer; pready is awaited, never assumed
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic err,
    output logic [31:0] q);
    int i;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 50);
    q = prdata;
    check("pslverr", {31'h0, err}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (i >= 50) begin n_mismatch++; results(); end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic err);
    logic [31:0] q;
    apb(1'b1, a, d, err, q);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp, logic err);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, err, q);
    check("prdata", exp, q);
  endtask
  task automatic wait_done();
    logic [31:0] q;
    int i;
    q = 0;
    for (i = 0; q[`STAT_DONE] !== 1'b1 && i < 300; i++)
      apb(1'b0, `REG_STATUS, 32'h0, 1'b0, q);
    if (i >= 300) begin n_mismatch++; results(); end
  endtask
  // one halfword cycle at the port, read data compared
  task automatic op(logic [1:0] c, logic r, logic [15:0] d, logic [15:0] e);
    wr(`REG_WDATA, {16'h0, d}, 1'b0);
    wr(`REG_COMMAND, {29'h0, r, c}, 1'b0);
    wait_done();
    if (r) rd(`REG_RDATA, {16'h0, e}, 1'b0);
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_reset();
    rd(`REG_CONFIG, 32'h0, 1'b0);
    rd(`REG_STATUS, 32'h4, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    wr(`REG_RDATA, 32'h1, 1'b1);
  endtask
  task automatic t_flow(logic [2:0] cfg);
    logic [15:0] a;
    a = {8'hA0, 5'h0, cfg};
    delay <= {cfg, 1'b1}; // prompt through slow device
    wr(`REG_CONFIG, {29'h0, cfg}, 1'b0);
    op(`ACC_CONTROL, 1'b0, 16'h0006, 16'h0);
    op(`ACC_ADDRESS, 1'b0, 16'h0003, 16'h0);
    op(`ACC_CONTROL, 1'b0, 16'h0002, 16'h0);
    op(`ACC_ADDRESS, 1'b0, 16'h0003, 16'h0);
    op(`ACC_DATA_INC, 1'b0, a, 16'h0);
    op(`ACC_DATA, 1'b0, ~a, 16'h0);
    op(`ACC_ADDRESS, 1'b1, 16'h0, 16'h0004);
    op(`ACC_DATA_INC, 1'b1, 16'h0, a);
    op(`ACC_DATA, 1'b1, 16'h0, ~a);
    op(`ACC_DATA, 1'b1, 16'h0, ~a);
    op(`ACC_CONTROL, 1'b1, 16'h0, 16'h0002);
  endtask
  // orders while busy are refused and leave the cycle intact
  task automatic t_busy();
    delay <= 4'hF;
    wr(`REG_COMMAND, {28'h0, 1'b1, 1'b1, `ACC_CONTROL}, 1'b0);
    wr(`REG_COMMAND, 32'h0, 1'b1);
    wr(`REG_CONFIG, 32'h0, 1'b1);
    rd(`REG_COMMAND, 32'hC, 1'b0);
    rd(`REG_STATUS, 32'h1, 1'b0);
    wait_done();
    rd(`REG_RDATA, 32'h0002, 1'b0);
    wr(`REG_STATUS, 32'h2, 1'b0);
    rd(`REG_STATUS, 32'h4, 1'b0);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; delay = 4'h1;
    n_mismatch = 0; checks_done = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    for (int c = 0; c < 8; c++) t_flow(c[2:0]);
    t_busy();
    results();
  end
endmodule
